/* hdl/libe_exec.sv */
module libe_exec #(
   parameter int unsigned CLKS_PER_MC = libe_pkg::MC_CLKS_DEF,
   parameter logic [7:0] JBC_OPCODE = libe_pkg::OPC_JBC_DEF
) (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic i_issue_valid,
   input wire libe_pkg::libe_instr_t i_issue,
   output logic o_ready,
   input wire logic [1:0] i_bank,
   input wire logic [7:0] i_rd_data,
   input wire logic [7:0] i_acc,
   input wire logic [15:0] i_data_pointer,
   output libe_pkg::libe_mem_t o_mem,
   output logic o_acc_we,
   output logic [7:0] o_acc,
   output logic o_data_pointer_we,
   output logic [15:0] o_data_pointer,
   output logic o_done,
   output logic o_taken,
   output logic [15:0] o_pc,
   output logic o_unsupported
);
   import libe_pkg::*;

   // The whole state of the sequencer.
   typedef struct packed {
      libe_state_t st;
      libe_op_t op;
      libe_instr_t ins;
      logic [2:0] bitsel;
      logic [1:0] mc_left;
      logic [DIV_W-1:0] div;
      libe_mem_t mem;
      logic acc_we;
      logic [7:0] acc;
      logic data_pointer_we;
      logic [15:0] data_pointer;
      logic done;
      logic taken;
      logic [15:0] pc;
      logic unsup;
   } libe_regs_t;

   // The sequencer needs a few clocks of each machine cycle for its own steps.
   if (CLKS_PER_MC < MC_CLKS_MIN || CLKS_PER_MC > MC_CLKS_MAX)
   begin : g_bad_clks
      $error("CLKS_PER_MC out of the range that the sequencer serves.");
   end

   libe_regs_t regs_r;
   libe_regs_t regs_nxt;
   libe_op_t dec_op;
   logic mc_tick;
   logic [1:0] op_len;
   logic [1:0] op_cyc;
   logic [7:0] rel;
   logic [15:0] pc_seq;
   logic [15:0] pc_tgt;
   logic [7:0] bit_byte;
   logic bit_val;
   logic [7:0] cleared;

   // Opcode decode of the issued instruction.
   always_comb
   begin
      dec_op = OP_NONE;
      if (i_issue.opcode == OPC_INC_ACC)
      begin
         dec_op = OP_INC_ACC;
      end
      else if (i_issue.opcode == OPC_INC_DIR)
      begin
         dec_op = OP_INC_DIR;
      end
      else if (i_issue.opcode[7:1] == OPC_INC_IND_PFX)
      begin
         dec_op = OP_INC_IND;
      end
      else if (i_issue.opcode[7:3] == OPC_INC_REG_PFX)
      begin
         dec_op = OP_INC_REG;
      end
      else if (i_issue.opcode == OPC_INC_DATA_POINTER)
      begin
         dec_op = OP_INC_DATA_POINTER;
      end
      else if (i_issue.opcode[7:3] == OPC_DECREMENT_BRANCH_NONZERO_REG_PFX)
      begin
         dec_op = OP_DECREMENT_BRANCH_NONZERO_REG;
      end
      else if (i_issue.opcode == OPC_DECREMENT_BRANCH_NONZERO_DIR)
      begin
         dec_op = OP_DECREMENT_BRANCH_NONZERO_DIR;
      end
      else if (i_issue.opcode == OPC_JB)
      begin
         dec_op = OP_JB;
      end
      else if (i_issue.opcode == JBC_OPCODE)
      begin
         // The clearing bit branch has its encoding set by a parameter.
         dec_op = OP_JBC;
      end
   end

   // Length and duration of the operation being executed.
   always_comb
   begin
      op_len = LEN_1;
      op_cyc = CYC_1;
      rel = regs_r.ins.byte2;
      unique case (regs_r.op)
         OP_INC_DIR:
         begin
            op_len = LEN_2;
         end
         OP_INC_DATA_POINTER:
         begin
            op_cyc = CYC_2;
         end
         OP_DECREMENT_BRANCH_NONZERO_REG:
         begin
            op_len = LEN_2;
            op_cyc = CYC_2;
            rel = regs_r.ins.byte1;
         end
         OP_DECREMENT_BRANCH_NONZERO_DIR, OP_JB, OP_JBC:
         begin
            op_len = LEN_3;
            op_cyc = CYC_2;
         end
         default:
         begin
            op_len = LEN_1;
         end
      endcase
   end

   // Branch target: the following instruction plus the signed offset.
   assign pc_seq = regs_r.ins.pc + {14'h0000, op_len};
   assign pc_tgt = pc_seq + {{8{rel[7]}}, rel};

   // Byte holding an addressed bit, the bit itself and the byte with it cleared.
   assign bit_byte = (i_issue.byte1 < SFR_BASE) ?
      (BIT_AREA_BASE + {4'h0, i_issue.byte1[6:3]}) : {i_issue.byte1[7:3], 3'b000};
   assign bit_val = i_rd_data[regs_r.bitsel];
   assign cleared = i_rd_data & ~(8'h01 << regs_r.bitsel);

   // Machine cycle divider pulse.
   assign mc_tick = (regs_r.div == DIV_W'(CLKS_PER_MC - 1));

   // Next state of the sequencer.
   always_comb
   begin
      regs_nxt = regs_r;
      regs_nxt.mem.rd_en = 1'b0;
      regs_nxt.mem.wr_en = 1'b0;
      regs_nxt.acc_we = 1'b0;
      regs_nxt.data_pointer_we = 1'b0;
      regs_nxt.done = 1'b0;
      regs_nxt.unsup = 1'b0;
      if (regs_r.st != ST_IDLE)
      begin
         regs_nxt.div = mc_tick ? '0 : regs_r.div + 1'b1;
         if (mc_tick)
         begin
            regs_nxt.mc_left = regs_r.mc_left - 2'h1;
         end
      end
      unique case (regs_r.st)
         ST_IDLE:
         begin
            if (i_issue_valid)
            begin
               regs_nxt.ins = i_issue;
               regs_nxt.op = dec_op;
               regs_nxt.div = '0;
               regs_nxt.taken = 1'b0;
               regs_nxt.mem.indirect = 1'b0;
               regs_nxt.mem.latch = 1'b1;
               regs_nxt.mem.rd_en = 1'b1;
               regs_nxt.bitsel = i_issue.byte1[2:0];
               regs_nxt.mc_left = CYC_1;
               regs_nxt.st = ST_READ;
               unique case (dec_op)
                  OP_INC_ACC:
                  begin
                     regs_nxt.mem.rd_en = 1'b0;
                     regs_nxt.st = ST_EXEC;
                  end
                  OP_INC_DATA_POINTER:
                  begin
                     regs_nxt.mem.rd_en = 1'b0;
                     regs_nxt.mc_left = CYC_2;
                     regs_nxt.st = ST_EXEC;
                  end
                  OP_INC_REG, OP_DECREMENT_BRANCH_NONZERO_REG:
                  begin
                     regs_nxt.mem.addr = {3'b000, i_bank, i_issue.opcode[2:0]};
                     regs_nxt.mc_left = (dec_op == OP_DECREMENT_BRANCH_NONZERO_REG) ? CYC_2 : CYC_1;
                  end
                  OP_INC_DIR, OP_DECREMENT_BRANCH_NONZERO_DIR:
                  begin
                     regs_nxt.mem.addr = i_issue.byte1;
                     regs_nxt.mc_left = (dec_op == OP_DECREMENT_BRANCH_NONZERO_DIR) ? CYC_2 : CYC_1;
                  end
                  OP_INC_IND:
                  begin
                     regs_nxt.mem.addr = {3'b000, i_bank, 2'b00, i_issue.opcode[0]};
                     regs_nxt.mem.latch = 1'b0;
                     regs_nxt.st = ST_PTR;
                  end
                  OP_JB, OP_JBC:
                  begin
                     regs_nxt.mem.addr = bit_byte;
                     regs_nxt.mem.latch = (dec_op == OP_JBC);
                     regs_nxt.mc_left = CYC_2;
                  end
                  default:
                  begin
                     regs_nxt.mem.rd_en = 1'b0;
                     // Opcodes outside this group are flagged and dropped.
                     regs_nxt.unsup = 1'b1;
                     regs_nxt.st = ST_IDLE;
                  end
               endcase
            end
         end
         ST_PTR:
         begin
            // The pointer register read is under way.
            regs_nxt.st = ST_PTRD;
         end
         ST_PTRD:
         begin
            // The pointer value has arrived; fetch the byte it points at.
            regs_nxt.mem.rd_en = 1'b1;
            regs_nxt.mem.addr = i_rd_data;
            regs_nxt.mem.indirect = 1'b1;
            regs_nxt.st = ST_READ;
         end
         ST_READ:
         begin
            // The operand byte arrives in the next cycle.
            regs_nxt.st = ST_EXEC;
         end
         ST_EXEC:
         begin
            regs_nxt.pc = pc_seq;
            // Reload the cycle count from the decoded duration; no tick can fall here.
            regs_nxt.mc_left = op_cyc;
            // By default the result is the byte read plus one.
            regs_nxt.mem.wdata = i_rd_data + 8'h01;
            unique case (regs_r.op)
               OP_INC_ACC:
               begin
                  regs_nxt.acc_we = 1'b1;
                  regs_nxt.acc = i_acc + 8'h01;
               end
               OP_INC_DATA_POINTER:
               begin
                  regs_nxt.data_pointer_we = 1'b1;
                  regs_nxt.data_pointer = i_data_pointer + 16'h0001;
               end
               OP_INC_REG, OP_INC_DIR, OP_INC_IND:
               begin
                  regs_nxt.mem.wr_en = 1'b1;
               end
               OP_DECREMENT_BRANCH_NONZERO_REG, OP_DECREMENT_BRANCH_NONZERO_DIR:
               begin
                  regs_nxt.mem.wr_en = 1'b1;
                  regs_nxt.mem.wdata = i_rd_data - 8'h01;
                  if (i_rd_data != 8'h01)
                  begin
                     regs_nxt.taken = 1'b1;
                     regs_nxt.pc = pc_tgt;
                  end
               end
               OP_JB, OP_JBC:
               begin
                  // A clear bit falls through with no write.
                  if (bit_val)
                  begin
                     regs_nxt.taken = 1'b1;
                     regs_nxt.pc = pc_tgt;
                     regs_nxt.mem.wdata = cleared;
                     regs_nxt.mem.wr_en = (regs_r.op == OP_JBC);
                  end
               end
               default:
               begin
                  regs_nxt.taken = 1'b0;
               end
            endcase
            regs_nxt.st = ST_HOLD;
         end
         ST_HOLD:
         begin
            // Wait out the instruction's number of machine cycles.
            if (mc_tick && regs_r.mc_left == CYC_1)
            begin
               regs_nxt.done = 1'b1;
               regs_nxt.st = ST_IDLE;
            end
         end
         default:
         begin
            regs_nxt.st = ST_IDLE;
         end
      endcase
   end

   // State register with synchronous reset.
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         // Every field clears; the named ones restate their values after reset.
         regs_r <= '0;
         regs_r.st <= ST_IDLE;
         regs_r.op <= OP_NONE;
         regs_r.pc <= PC_RST;
         regs_r.acc <= BYTE_RST;
      end
      else
      begin
         regs_r <= regs_nxt;
      end
   end

   // Outputs come straight from the state, ready from the state code.
   assign o_ready = (regs_r.st == ST_IDLE);
   assign o_mem = regs_r.mem;
   assign o_acc_we = regs_r.acc_we;
   assign o_acc = regs_r.acc;
   assign o_data_pointer_we = regs_r.data_pointer_we;
   assign o_data_pointer = regs_r.data_pointer;
   assign o_done = regs_r.done;
   assign o_taken = regs_r.taken;
   assign o_pc = regs_r.pc;
   assign o_unsupported = regs_r.unsup;

endmodule : libe_exec

/* hdl/libe_pkg.sv */
// Summary of operation
// - Decrement loop operand, branch if nonzero.
// - Zero wraps to all ones; flags untouched.
// - Loop target: next instruction plus offset.
// - Loop operand: work register or direct byte.
// - Modify ports through the output latch.
// - Register loop form: two bytes, two cycles.
// - Direct loop form: three bytes, two cycles.
// - Byte increment wraps; flags untouched.
// - Increment register, direct, indirect and accumulator.
// - Direct increment: two bytes, one cycle.
// - Data pointer increments modulo sixteen bits.
// - Bit branch when set, bit kept.
// - Bit branch: three bytes, two cycles.
// - Bit branch target: next instruction plus offset.
// - Branch-and-clear clears a set bit only.
// - Branch-and-clear reads the port latch.
package libe_pkg;

   // Machine cycle length in core clocks and the least that the sequencer can serve.
   localparam int unsigned MC_CLKS_DEF = 12;
   localparam int unsigned MC_CLKS_MIN = 6;
   localparam int unsigned MC_CLKS_MAX = 256;
   localparam int unsigned DIV_W = 8;

   // Opcodes and opcode prefixes.
   localparam logic [7:0] OPC_INC_ACC = 8'h04;
   localparam logic [7:0] OPC_INC_DIR = 8'h05;
   localparam logic [6:0] OPC_INC_IND_PFX = 7'h03;
   localparam logic [4:0] OPC_INC_REG_PFX = 5'h01;
   localparam logic [7:0] OPC_INC_DATA_POINTER = 8'ha3;
   localparam logic [4:0] OPC_DECREMENT_BRANCH_NONZERO_REG_PFX = 5'h1b;
   localparam logic [7:0] OPC_DECREMENT_BRANCH_NONZERO_DIR = 8'hd5;
   localparam logic [7:0] OPC_JB = 8'h20;
   localparam logic [7:0] OPC_JBC_DEF = 8'h10;

   // Bit addressing: low bit numbers map into a byte area, high ones into special registers.
   localparam logic [7:0] BIT_AREA_BASE = 8'h20;
   localparam logic [7:0] SFR_BASE = 8'h80;

   // Instruction lengths in bytes and durations in machine cycles.
   localparam logic [1:0] LEN_1 = 2'h1;
   localparam logic [1:0] LEN_2 = 2'h2;
   localparam logic [1:0] LEN_3 = 2'h3;
   localparam logic [1:0] CYC_1 = 2'h1;
   localparam logic [1:0] CYC_2 = 2'h2;

   // Values after reset.
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [15:0] PC_RST = 16'h0000;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_PTR = 3'b001,
      ST_PTRD = 3'b010,
      ST_READ = 3'b011,
      ST_EXEC = 3'b100,
      ST_HOLD = 3'b101
   } libe_state_t;

   typedef enum logic [3:0] {
      OP_NONE = 4'b0000,
      OP_INC_ACC = 4'b0001,
      OP_INC_REG = 4'b0010,
      OP_INC_DIR = 4'b0011,
      OP_INC_IND = 4'b0100,
      OP_INC_DATA_POINTER = 4'b0101,
      OP_DECREMENT_BRANCH_NONZERO_REG = 4'b0110,
      OP_DECREMENT_BRANCH_NONZERO_DIR = 4'b0111,
      OP_JB = 4'b1000,
      OP_JBC = 4'b1001
   } libe_op_t;

   // One instruction as handed over by the fetch logic.
   typedef struct packed {
      logic [7:0] opcode;
      logic [7:0] byte1;
      logic [7:0] byte2;
      logic [15:0] pc;
   } libe_instr_t;

   // Internal data memory access request.
   typedef struct packed {
      logic rd_en;
      logic wr_en;
      logic indirect;
      logic latch;
      logic [7:0] addr;
      logic [7:0] wdata;
   } libe_mem_t;

endpackage : libe_pkg

/* verif/libe_exec_props.sv */
module libe_exec_props #(
   parameter int unsigned CLKS_PER_MC = libe_pkg::MC_CLKS_DEF,
   parameter logic [7:0] JBC_OPCODE = libe_pkg::OPC_JBC_DEF
) (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic i_issue_valid,
   input wire libe_pkg::libe_instr_t i_issue,
   input wire logic o_ready,
   input wire logic [1:0] i_bank,
   input wire logic [7:0] i_rd_data,
   input wire logic [7:0] i_acc,
   input wire logic [15:0] i_data_pointer,
   input wire libe_pkg::libe_mem_t o_mem,
   input wire logic o_acc_we,
   input wire logic [7:0] o_acc,
   input wire logic o_data_pointer_we,
   input wire logic [15:0] o_data_pointer,
   input wire logic o_done,
   input wire logic o_taken,
   input wire logic [15:0] o_pc,
   input wire logic o_unsupported
);
   import libe_pkg::*;

   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_sys_rst);

   logic busy_r;
   logic rdd_r;
   logic [9:0] cnt_r;
   logic [1:0] bank_r;
   logic [7:0] dat_r;
   libe_instr_t ins_r;

   // Track the accepted instruction, its age in cycles and the last byte read.
   always_ff @(posedge i_ref_clk)
   begin
      rdd_r <= o_mem.rd_en && !i_sys_rst;
      if (rdd_r)
         dat_r <= i_rd_data;
      if (i_sys_rst)
         busy_r <= 1'b0;
      else if (o_ready && i_issue_valid)
      begin
         busy_r <= 1'b1;
         cnt_r <= 10'h000;
         ins_r <= i_issue;
         bank_r <= i_bank;
      end
      else if (o_done)
         busy_r <= 1'b0;
      else
         cnt_r <= cnt_r + 10'h001;
   end

   logic [7:0] op;
   logic is_decrement_branch_nonzero;
   logic is_bit;
   logic is_inc;
   logic two;
   logic [15:0] len;
   logic [7:0] off;
   logic [2:0] bi;

   // Decode the held opcode into its class, length and offset byte.
   assign op = ins_r.opcode;
   assign is_decrement_branch_nonzero = (op[7:3] == OPC_DECREMENT_BRANCH_NONZERO_REG_PFX) || (op == OPC_DECREMENT_BRANCH_NONZERO_DIR);
   assign is_bit = (op == OPC_JB) || (op == JBC_OPCODE);
   assign is_inc = (op == OPC_INC_DIR) || (op[7:1] == OPC_INC_IND_PFX) ||
                   (op[7:3] == OPC_INC_REG_PFX);
   assign two = is_decrement_branch_nonzero || is_bit || (op == OPC_INC_DATA_POINTER);
   assign len = (op == OPC_INC_DIR || op[7:3] == OPC_DECREMENT_BRANCH_NONZERO_REG_PFX) ? 16'h0002 :
                (op == OPC_DECREMENT_BRANCH_NONZERO_DIR || is_bit) ? 16'h0003 : 16'h0001;
   assign off = (op[7:3] == OPC_DECREMENT_BRANCH_NONZERO_REG_PFX) ? ins_r.byte1 : ins_r.byte2;
   assign bi = ins_r.byte1[2:0];

   property p_dur;
      o_done |-> int'(cnt_r) == (two ? 2 : 1) * CLKS_PER_MC;
   endproperty
   a_dur: assert property (p_dur) else $error("done at wrong cycle");

   property p_inc_wr;
      o_mem.wr_en && is_inc |-> o_mem.wdata == dat_r + 8'h01;
   endproperty
   a_inc_wr: assert property (p_inc_wr) else $error("increment wrong");

   property p_decrement_branch_nonzero_wr;
      o_mem.wr_en && is_decrement_branch_nonzero |-> o_mem.wdata == dat_r - 8'h01;
   endproperty
   a_decrement_branch_nonzero_wr: assert property (p_decrement_branch_nonzero_wr) else $error("decrement wrong");

   property p_bit_wr;
      o_mem.wr_en && busy_r && is_bit |-> op == JBC_OPCODE && dat_r[bi] &&
         o_mem.wdata == (dat_r & ~(8'h01 << bi));
   endproperty
   a_bit_wr: assert property (p_bit_wr) else $error("bit write wrong");

   property p_taken;
      o_done |-> o_taken == (is_decrement_branch_nonzero ? (dat_r != 8'h01) : (is_bit && dat_r[bi]));
   endproperty
   a_taken: assert property (p_taken) else $error("taken wrong");

   property p_target;
      o_done |-> o_pc == ins_r.pc + len + (o_taken ? {{8{off[7]}}, off} : 16'h0000);
   endproperty
   a_target: assert property (p_target) else $error("next pc wrong");

   property p_latch;
      o_mem.rd_en && busy_r && (is_decrement_branch_nonzero || op == JBC_OPCODE || op == OPC_INC_DIR ||
         op[7:3] == OPC_INC_REG_PFX) |-> o_mem.latch;
   endproperty
   a_latch: assert property (p_latch) else $error("pin read for port");

   property p_reg_addr;
      o_mem.rd_en && cnt_r == 10'h000 &&
         (op[7:3] == OPC_DECREMENT_BRANCH_NONZERO_REG_PFX || op[7:3] == OPC_INC_REG_PFX)
         |-> o_mem.addr == {3'b000, bank_r, op[2:0]};
   endproperty
   a_reg_addr: assert property (p_reg_addr) else $error("register address wrong");

   property p_data_pointer;
      o_data_pointer_we |-> o_data_pointer == $past(i_data_pointer) + 16'h0001;
   endproperty
   a_data_pointer: assert property (p_data_pointer) else $error("data pointer wrong");

   property p_acc;
      o_acc_we |-> o_acc == $past(i_acc) + 8'h01;
   endproperty
   a_acc: assert property (p_acc) else $error("accumulator wrong");

endmodule : libe_exec_props

bind libe_exec libe_exec_props #(.CLKS_PER_MC(CLKS_PER_MC), .JBC_OPCODE(JBC_OPCODE)) u_props (
   .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_issue_valid(i_issue_valid),
   .i_issue(i_issue), .o_ready(o_ready), .i_bank(i_bank), .i_rd_data(i_rd_data),
   .i_acc(i_acc), .i_data_pointer(i_data_pointer), .o_mem(o_mem), .o_acc_we(o_acc_we), .o_acc(o_acc),
   .o_data_pointer_we(o_data_pointer_we), .o_data_pointer(o_data_pointer), .o_done(o_done), .o_taken(o_taken),
   .o_pc(o_pc), .o_unsupported(o_unsupported));

/* verif/loop_increment_branch_exec_bench.sv */
module loop_increment_branch_exec_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import libe_pkg::*;

   localparam int CLKS = 6;
   logic ref_clk, sys_rst, issue_valid, ready, acc_we, data_pointer_we, done, taken, unsup;
   logic [1:0] bank;
   logic [7:0] rd_data, acc, acc_o;
   logic [15:0] data_pointer, data_pointer_o, pc_o;
   libe_instr_t issue;
   libe_mem_t mem_req;
   logic [7:0] mem [256];
   logic [7:0] ops [10] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'ha3, 8'hd5, 8'hd8, 8'h20,
                            8'h10};
   logic [7:0] op;
   int err_count, num_checks, seed;

   libe_exec #(.CLKS_PER_MC(CLKS)) u_dut (
      .i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .i_issue_valid(issue_valid),
      .i_issue(issue), .o_ready(ready), .i_bank(bank), .i_rd_data(rd_data), .i_acc(acc),
      .i_data_pointer(data_pointer), .o_mem(mem_req), .o_acc_we(acc_we), .o_acc(acc_o),
      .o_data_pointer_we(data_pointer_we), .o_data_pointer(data_pointer_o), .o_done(done), .o_taken(taken), .o_pc(pc_o),
      .o_unsupported(unsup));

   // Free-running core clock.
   initial
   begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   // Data memory: one cycle read latency, a changing pattern when not read.
   always @(posedge ref_clk)
   begin
      rd_data <= sys_rst ? 8'h00 : (mem_req.rd_en ? mem[mem_req.addr] : ~rd_data);
      if (mem_req.wr_en)
         mem[mem_req.addr] <= mem_req.wdata;
   end

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : end_sim

   // Model one instruction, issue it, wait for completion and compare.
   task automatic run(input logic [7:0] opc, input logic [7:0] b1, input logic [7:0] b2);
      logic [15:0] pc, exp_pc;
      logic [7:0] a, v, off;
      logic tk;
      int n, len, k;
      pc = 16'($random(seed));
      n = 1;
      len = 1;
      tk = 1'b0;
      off = b2;
      a = b1;
      if (opc[7:3] == 5'h01 || opc[7:3] == 5'h1b)
         a = {3'b000, bank, opc[2:0]};
      if (opc[7:1] == 7'h03)
         a = mem[{3'b000, bank, 2'b00, opc[0]}];
      if (opc == 8'h20 || opc == 8'h10)
         a = b1[7] ? {b1[7:3], 3'b000} : 8'h20 + b1[6:3];
      v = (opc == 8'h04 || opc == 8'ha3) ? mem[a] : mem[a] + 8'h01;
      if (opc == 8'h05)
         len = 2;
      if (opc[7:3] == 5'h1b || opc == 8'hd5)
      begin
         n = 2;
         v = mem[a] - 8'h01;
         tk = v != 8'h00;
         len = opc[3] ? 2 : 3;
         off = opc[3] ? b1 : b2;
      end
      if (opc == 8'h20 || opc == 8'h10)
      begin
         n = 2;
         len = 3;
         v = mem[a];
         tk = v[b1[2:0]];
         if (opc == 8'h10)
            v[b1[2:0]] = 1'b0;
      end
      if (opc == 8'ha3)
         n = 2;
      @(posedge ref_clk);
      issue_valid <= 1'b1;
      issue <= '{opc, b1, b2, pc};
      @(posedge ref_clk);
      issue_valid <= 1'b0;
      for (k = 1; k <= 3 * CLKS; k++)
      begin
         @(posedge ref_clk);
         #1;
         if (done === 1'b1)
            break;
      end
      if (k > 3 * CLKS)
      begin
         err_count++;
         end_sim();
      end
      else
      begin
         exp_pc = pc + 16'(len) + (tk ? {{8{off[7]}}, off} : 16'h0000);
         chk("cycles", k, n * CLKS);
         chk("taken", taken, tk);
         chk("pc", pc_o, exp_pc);
         chk("byte", mem[a], v);
         if (opc == 8'h04)
            chk("acc", acc_o, 8'(acc + 8'h01));
         if (opc == 8'ha3)
            chk("data_pointer", data_pointer_o, 16'(data_pointer + 16'h0001));
      end
   endtask : run

   // Reset, then directed boundary cases, then random instructions.
   initial
   begin
      seed = 33505;
      err_count = 0;
      num_checks = 0;
      sys_rst = 1'b1;
      issue_valid = 1'b0;
      issue = '0;
      bank = 2'h0;
      acc = 8'h00;
      data_pointer = 16'h0000;
      foreach (mem[i])
         mem[i] = 8'($random(seed));
      repeat (5) @(posedge ref_clk);
      sys_rst <= 1'b0;
      acc <= 8'hff;
      data_pointer <= 16'h12ff;
      #1;
      mem[8'h03] = 8'h01;
      mem[8'h40] = 8'h00;
      mem[8'h7f] = 8'hff;
      mem[8'h20] = 8'h20;
      mem[8'h80] = 8'h00;
      run(8'hdb, 8'h10, 8'h00);
      run(8'hd5, 8'h40, 8'h80);
      run(8'h05, 8'h7f, 8'h00);
      run(8'h04, 8'h00, 8'h00);
      run(8'ha3, 8'h00, 8'h00);
      run(8'h10, 8'h05, 8'hfe);
      run(8'h20, 8'h83, 8'h7f);
      @(posedge ref_clk);
      data_pointer <= 16'hffff;
      #1;
      run(8'ha3, 8'h00, 8'h00);
      $display("directed cases done");
      // Reset in the middle of a loop instruction, then an opcode outside the group.
      @(posedge ref_clk);
      issue_valid <= 1'b1;
      issue <= '{8'hd5, 8'h41, 8'h10, 16'h1234};
      @(posedge ref_clk);
      issue_valid <= 1'b0;
      repeat (3) @(posedge ref_clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      #1;
      chk("rst ready", ready, 1'b1);
      chk("rst done", done, 1'b0);
      chk("rst taken", taken, 1'b0);
      chk("rst pc", pc_o, PC_RST);
      chk("rst acc", acc_o, BYTE_RST);
      chk("rst data_pointer", data_pointer_o, 16'h0000);
      chk("rst write", mem_req.wr_en, 1'b0);
      @(posedge ref_clk);
      issue_valid <= 1'b1;
      issue <= '{8'h00, 8'h00, 8'h00, 16'h0000};
      @(posedge ref_clk);
      issue_valid <= 1'b0;
      #1;
      chk("unsupported", unsup, 1'b1);
      chk("ready", ready, 1'b1);
      @(posedge ref_clk);
      #1;
      chk("unsupported", unsup, 1'b0);
      $display("reset and foreign opcode cases done");
      for (int i = 0; i < 60; i++)
      begin
         @(posedge ref_clk);
         bank <= 2'($random(seed));
         acc <= 8'($random(seed));
         data_pointer <= 16'($random(seed));
         #1;
         op = ops[i % 10];
         if (op == 8'h08 || op == 8'hd8)
            op[2:0] = 3'($random(seed));
         run(op, 8'($random(seed)), 8'($random(seed)));
      end
      $display("random cases done");
      end_sim();
   end

endmodule : loop_increment_branch_exec_bench
